// >>> hdl/cmd_fifo_defines.vh
// Constants for the command and response FIFO handshake block
// Function
// RULE_01 - A single identity and configuration copy is readable from every locality.
// RULE_02 - Separate per-locality identity copies always hold identical contents.
// RULE_03 - Never drop a bus cycle on internal stall; hold the bus with waits.
// RULE_04 - Host reads status first and writes prepare-command before command bytes.
// RULE_05 - A prepare-command write makes the device get ready for a command.
// RULE_06 - When ready, prepare-command reads one and depth count is nonzero.
// RULE_07 - First command byte clears prepare-command, sets expected, depth keeps updating.
// RULE_08 - Total command length comes from the size field in leading bytes.
// RULE_09 - Expected stays one until the final command byte, then clears.
// RULE_10 - While expected is zero, further data bytes are dropped.
// RULE_11 - Execute trigger writes are ignored until expected has fallen to zero.
// RULE_12 - Host writes execute trigger; device then starts executing the buffered command.
// RULE_13 - On completion, response bytes enter the FIFO and response-pending sets.
// RULE_14 - Response-pending clears once the final response byte is read out.
// RULE_15 - Depth count nonzero when reading may start, then shows available bytes.
// RULE_16 - Host waits for nonzero depth count before reading the response.
// RULE_17 - Depth count shows only movable bytes; flags carry direction and expectation.
// RULE_18 - Abort on prepare during receive or execute, takeover, release, hash start.
// RULE_19 - After abort, halt the command, flush both directions, return idle.
// RULE_20 - After abort, state is pre-command or post-command, never intermediate.
// RULE_21 - Abort honoured within short limit, or long limit for key generation.
// RULE_22 - A response is never returned to a different locality after abort.
// RULE_23 - Host releases locality by writing locality-owned; this aborts any command.
// RULE_24 - After reset: idle, all flags clear, depth zero, FIFO empty.
`ifndef CMD_FIFO_DEFINES_VH
`define CMD_FIFO_DEFINES_VH

// FIFO geometry
`define FIFO_DEPTH      64
`define FIFO_AW         6

// Size field position inside the command header (big endian)
`define SIZE_FIRST_BYTE 2
`define SIZE_LAST_BYTE  5
`define HDR_MIN_BYTES   6

// Byte answered to reads outside the response phase
`define IDLE_READ_BYTE  8'hff

// Clock rate and abort limits
`define CLK_HZ          50000000
`define ABORT_SHORT_MS  750
`define ABORT_LONG_MS   2000

// Identity values (arbitrary, neutral)
`define DEV_VEN_ID_VAL  32'h0000_0001
`define REV_ID_VAL      8'h01

`endif

// >>> hdl/fifo_byte_mem.v
// Byte memory shared by the command and response directions
`timescale 1ns/1ps
module fifo_byte_mem #(
   parameter DW = 8,
   parameter AW = 6
) (
   // Clock and reset
   input  wire          clk,
   input  wire          rst_b,
   // Write port
   input  wire          wr_en,
   input  wire [AW-1:0] wr_addr,
   input  wire [DW-1:0] wr_data,
   // Read port, data registered
   input  wire          rd_en,
   input  wire [AW-1:0] rd_addr,
   output reg  [DW-1:0] rd_data
);

   reg [DW-1:0] mem [0:(1<<AW)-1];

   // Array write, no reset on storage
   always @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // Registered read
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_data <= {DW{1'b0}};
      end else if (rd_en) begin
         rd_data <= mem[rd_addr];
      end
   end

endmodule // fifo_byte_mem

// >>> hdl/cmd_fifo_handshake.v
// Command and response FIFO handshake of the host interface
`timescale 1ns/1ps
`include "cmd_fifo_defines.vh"
module cmd_fifo_handshake #(
   parameter DEPTH          = `FIFO_DEPTH,
   parameter AW             = `FIFO_AW,
   parameter ABORT_SHORT_MS = `ABORT_SHORT_MS,
   parameter ABORT_LONG_MS  = `ABORT_LONG_MS,
   parameter [31:0] ABORT_SHORT_CYC = ms_to_cyc(ABORT_SHORT_MS),
   parameter [31:0] ABORT_LONG_CYC  = ms_to_cyc(ABORT_LONG_MS)
) (
   // Clock and reset
   input  wire          clk,
   input  wire          rst_b,
   // Data port accesses from the bus controller
   input  wire          fifo_wr_req,
   input  wire [7:0]    fifo_wr_data,
   input  wire          fifo_rd_req,
   output wire          bus_wait,
   output reg           fifo_rd_valid,
   output wire [7:0]    fifo_rd_data,
   // Status and access strobes from the bus controller
   input  wire          prepare_command_wr,
   input  wire          execute_trigger_wr,
   input  wire          locality_owned_wr,
   input  wire          seize_ok,
   input  wire          hash_start_done,
   // Status fields
   output reg           prepare_command,
   output reg           more_input_expected,
   output reg           response_pending,
   output reg  [AW:0]   fifo_depth_count,
   // Identity, one copy seen by all localities
   output reg  [31:0]   device_vendor_ids,
   output reg  [7:0]    revision_id_register,
   // Execution engine side
   output reg           exec_start,
   output reg           exec_abort,
   input  wire          abort_ack,
   input  wire          rsa_keygen,
   input  wire          cmd_take,
   output reg           cmd_byte_valid,
   output wire [7:0]    cmd_byte,
   input  wire          rsp_valid,
   input  wire [7:0]    rsp_data,
   input  wire          rsp_last,
   output wire          rsp_ready
);

   // Milliseconds to clock cycles, rounded down
   function [31:0] ms_to_cyc;
      input integer ms;
      begin
         ms_to_cyc = ms * (`CLK_HZ / 1000);
      end
   endfunction

   localparam [2:0] ST_IDLE  = 3'h0;
   localparam [2:0] ST_READY = 3'h1;
   localparam [2:0] ST_RECV  = 3'h2;
   localparam [2:0] ST_EXEC  = 3'h3;
   localparam [2:0] ST_RESP  = 3'h4;
   localparam [2:0] ST_ABORT = 3'h5;

   localparam [AW:0] DEPTH_C = DEPTH;
   localparam [AW:0] HDR_MIN = `HDR_MIN_BYTES;
   localparam [AW:0] SZ_LO   = `SIZE_FIRST_BYTE;
   localparam [AW:0] SZ_HI   = `SIZE_LAST_BYTE;

   reg  [2:0]    state_reg;
   reg  [2:0]    state_next;
   reg  [AW:0]   wptr_reg;
   reg  [AW:0]   rptr_reg;
   reg  [AW:0]   cmd_cnt_reg;
   reg  [31:0]   len_reg;
   reg  [31:0]   len_next;
   reg  [31:0]   timer_reg;
   reg           rd_idle_reg;
   reg  [AW:0]   depth_next;
   wire [7:0]    mem_q;
   wire [AW:0]   wcnt_inc;
   wire          abort_evt;
   wire          loc_evt;
   wire          wr_store;
   wire          wr_drop;
   wire          rd_host;
   wire          rd_idle;
   wire          cmd_ok;
   wire          rsp_store;
   wire          rx_done;
   wire          go_ok;

   // Locality change, takeover or hash start always abort
   assign loc_evt   = seize_ok | locality_owned_wr | hash_start_done; // [RULE_23]
   assign abort_evt = loc_evt | (prepare_command_wr &
                      ((state_reg == ST_RECV) | (state_reg == ST_EXEC))); // [RULE_18]

   // Requests are held with a wait while an abort is being flushed
   assign bus_wait = (state_reg == ST_ABORT) & (fifo_wr_req | fifo_rd_req); // [RULE_03]

   // Write acceptance: stored while a command is expected, dropped otherwise
   assign wr_store = fifo_wr_req & ~bus_wait & ~abort_evt &
                     ((state_reg == ST_READY) | ((state_reg == ST_RECV) & more_input_expected));
   assign wr_drop  = fifo_wr_req & ~bus_wait & ~wr_store; // [RULE_10]

   // Read acceptance: response bytes in the response phase, filler otherwise
   assign rd_host = fifo_rd_req & ~bus_wait & ~abort_evt &
                    (state_reg == ST_RESP) & (rptr_reg < wptr_reg);
   assign rd_idle = fifo_rd_req & ~bus_wait & ~rd_host;

   // Engine side transfers; response bytes overwrite the command area,
   // so the engine must read the whole command before it answers
   assign cmd_ok    = cmd_take & (state_reg == ST_EXEC) & (rptr_reg < cmd_cnt_reg) & ~abort_evt;
   assign rsp_ready = (state_reg == ST_EXEC) & (wptr_reg < DEPTH_C) & ~abort_evt;
   assign rsp_store = rsp_valid & rsp_ready;
   assign cmd_byte  = mem_q;
   assign fifo_rd_data = rd_idle_reg ? `IDLE_READ_BYTE : mem_q;

   // Size field gathered from the header bytes
   assign wcnt_inc = wptr_reg + {{AW{1'b0}}, 1'b1};
   always @* begin
      len_next = len_reg;
      if (wr_store && (wptr_reg >= SZ_LO) && (wptr_reg <= SZ_HI)) begin
         len_next = {len_reg[23:0], fifo_wr_data}; // [RULE_08]
      end
   end

   // Last byte: header complete and size reached, or the buffer is full
   assign rx_done = wr_store & (((wcnt_inc >= HDR_MIN) &
                    ({{(31-AW){1'b0}}, wcnt_inc} >= len_next)) | (wcnt_inc == DEPTH_C)); // [RULE_09]

   // Execute trigger taken only once the whole command is in
   assign go_ok = execute_trigger_wr & (state_reg == ST_RECV) &
                  ~more_input_expected & ~abort_evt; // [RULE_11]

   // Shared byte store for both directions
   fifo_byte_mem #(
      .DW      (8),
      .AW      (AW)
   ) u_mem (
      .clk     (clk),
      .rst_b   (rst_b),
      .wr_en   (wr_store | rsp_store),
      .wr_addr (wptr_reg[AW-1:0]),
      .wr_data (wr_store ? fifo_wr_data : rsp_data),
      .rd_en   (rd_host | cmd_ok),
      .rd_addr (rptr_reg[AW-1:0]),
      .rd_data (mem_q)
   );

   // Sequencing of the command exchange
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (prepare_command_wr && !loc_evt) begin
               state_next = ST_READY; // [RULE_05]
            end
         end
         ST_READY: begin
            if (loc_evt) begin
               state_next = ST_IDLE;
            end else if (wr_store) begin
               state_next = ST_RECV; // [RULE_07]
            end
         end
         ST_RECV: begin
            if (abort_evt) begin
               state_next = ST_IDLE; // [RULE_19]
            end else if (go_ok) begin
               state_next = ST_EXEC; // [RULE_12]
            end
         end
         ST_EXEC: begin
            if (abort_evt) begin
               state_next = ST_ABORT;
            end else if (rsp_store && rsp_last) begin
               state_next = ST_RESP; // [RULE_13]
            end
         end
         ST_RESP: begin
            if (loc_evt) begin
               state_next = ST_IDLE; // [RULE_22]
            end else if (prepare_command_wr) begin
               state_next = ST_READY;
            end else if (rd_host && (rptr_reg + {{AW{1'b0}}, 1'b1} == wptr_reg)) begin
               state_next = ST_IDLE; // [RULE_14]
            end
         end
         ST_ABORT: begin
            // Engine confirms it rolled back or committed, or the limit expires
            if (abort_ack || (timer_reg == 32'h0000_0000)) begin
               state_next = ST_IDLE; // [RULE_20] [RULE_21]
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // Depth count shows only bytes movable without a stall
   always @* begin
      depth_next = {(AW+1){1'b0}};
      if (state_next == ST_READY) begin
         depth_next = DEPTH_C; // [RULE_06]
      end else if ((state_next == ST_RECV) && !rx_done && (more_input_expected || (state_reg == ST_READY))) begin
         depth_next = DEPTH_C - (wr_store ? wcnt_inc : wptr_reg); // [RULE_07] [RULE_17]
      end else if (state_next == ST_RESP) begin
         // First response cycle counts the bytes just stored; the read pointer resets on that edge
         if (state_reg == ST_EXEC) begin
            depth_next = wcnt_inc; // [RULE_13] [RULE_15]
         end else begin
            depth_next = wptr_reg - rptr_reg - {{AW{1'b0}}, rd_host}; // [RULE_15]
         end
      end
   end

   // State, pointers and flags
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg           <= ST_IDLE; // [RULE_24]
         wptr_reg            <= {(AW+1){1'b0}};
         rptr_reg            <= {(AW+1){1'b0}};
         cmd_cnt_reg         <= {(AW+1){1'b0}};
         len_reg             <= 32'h0000_0000;
         timer_reg           <= 32'h0000_0000;
         prepare_command     <= 1'b0;
         more_input_expected <= 1'b0;
         response_pending    <= 1'b0;
         fifo_depth_count    <= {(AW+1){1'b0}};
         exec_start          <= 1'b0;
         exec_abort          <= 1'b0;
         cmd_byte_valid      <= 1'b0;
         fifo_rd_valid       <= 1'b0;
         rd_idle_reg         <= 1'b0;
      end else begin
         state_reg        <= state_next;
         fifo_depth_count <= depth_next;
         exec_start       <= go_ok; // [RULE_12]
         cmd_byte_valid   <= cmd_ok;
         fifo_rd_valid    <= rd_host | rd_idle;
         rd_idle_reg      <= rd_idle;
         len_reg          <= len_next;
         if (cmd_ok || rd_host) begin
            rptr_reg <= rptr_reg + {{AW{1'b0}}, 1'b1};
         end
         if (wr_store || rsp_store) begin
            wptr_reg <= wcnt_inc;
         end
         // Abort limit timer, long limit for key generation
         if (state_reg == ST_EXEC && abort_evt) begin
            timer_reg  <= rsa_keygen ? ABORT_LONG_CYC : ABORT_SHORT_CYC; // [RULE_21]
            exec_abort <= 1'b1; // [RULE_19]
         end else if (state_reg == ST_ABORT) begin
            if (timer_reg != 32'h0000_0000) begin
               timer_reg <= timer_reg - 32'h0000_0001;
            end
            if (state_next == ST_IDLE) begin
               exec_abort <= 1'b0;
            end
         end
         // Entering idle or ready flushes both directions
         if ((state_next == ST_IDLE || state_next == ST_READY) && state_next != state_reg) begin
            wptr_reg            <= {(AW+1){1'b0}}; // [RULE_19] [RULE_22]
            rptr_reg            <= {(AW+1){1'b0}};
            len_reg             <= 32'h0000_0000;
            more_input_expected <= 1'b0;
            response_pending    <= 1'b0;
         end
         prepare_command <= (state_next == ST_READY); // [RULE_06] [RULE_07]
         if (state_reg == ST_READY && wr_store) begin
            more_input_expected <= ~rx_done; // [RULE_07]
         end else if (state_reg == ST_RECV && rx_done) begin
            more_input_expected <= 1'b0; // [RULE_09]
         end
         // Command handed over: response is written from the buffer start
         // The stored byte count bounds the engine's command reads
         if (go_ok) begin
            cmd_cnt_reg <= wptr_reg;
            wptr_reg    <= {(AW+1){1'b0}};
            rptr_reg    <= {(AW+1){1'b0}};
         end
         if (state_reg == ST_EXEC && state_next == ST_RESP) begin
            response_pending <= 1'b1; // [RULE_13]
            rptr_reg         <= {(AW+1){1'b0}};
         end
      end
   end

   // Identity registers exist once and are shared by all localities
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         device_vendor_ids    <= `DEV_VEN_ID_VAL; // [RULE_01] [RULE_02]
         revision_id_register <= `REV_ID_VAL;
      end else begin
         device_vendor_ids    <= `DEV_VEN_ID_VAL;
         revision_id_register <= `REV_ID_VAL;
      end
   end

endmodule // cmd_fifo_handshake

// >>> dv/cmd_fifo_monitor.sv
// Port checker for the command FIFO handshake block
`timescale 1ns/1ps
module cmd_fifo_monitor #(
   parameter AW = 6,
   parameter [31:0] ABORT_SHORT_CYC = 32'h14,
   parameter [31:0] ABORT_LONG_CYC = 32'h28
) (
   // Clock and reset
   input wire        clk,
   input wire        rst_b,
   // Host and engine inputs
   input wire        fifo_wr_req,
   input wire        fifo_rd_req,
   input wire        execute_trigger_wr,
   input wire        rsa_keygen,
   // Block outputs
   input wire        bus_wait,
   input wire        fifo_rd_valid,
   input wire        prepare_command,
   input wire        more_input_expected,
   input wire        response_pending,
   input wire [AW:0] fifo_depth_count,
   input wire        exec_start,
   input wire        exec_abort
);
   reg [31:0] abort_len_reg;
   // Cycles spent in the current abort
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) abort_len_reg <= 32'h0;
      else abort_len_reg <= exec_abort ? abort_len_reg + 32'h1 : 32'h0;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   a_ready_depth: assert property (prepare_command |-> fifo_depth_count != 0)
      else $error("ready without depth");
   a_go_ignored: assert property (execute_trigger_wr && more_input_expected |=> !exec_start)
      else $error("start while input expected");
   a_start_pulse: assert property (exec_start |=> !exec_start)
      else $error("start longer than one cycle");
   a_rsp_depth: assert property ($rose(response_pending) |-> fifo_depth_count != 0)
      else $error("response without depth");
   a_pend_clear: assert property ($fell(response_pending) && !prepare_command |-> fifo_depth_count == 0)
      else $error("pending cleared with bytes left");
   a_abort_stall: assert property (exec_abort && (fifo_wr_req || fifo_rd_req) |-> bus_wait)
      else $error("request not held in abort");
   a_read_answer: assert property (fifo_rd_req && !bus_wait |=> fifo_rd_valid)
      else $error("taken read not answered");
   a_abort_bound: assert property (abort_len_reg <= (rsa_keygen ? ABORT_LONG_CYC : ABORT_SHORT_CYC) + 32'h2)
      else $error("abort too long");
   a_abort_flush: assert property ($fell(exec_abort) |-> !response_pending && !more_input_expected
      && !prepare_command && fifo_depth_count == 0) else $error("abort left state behind");
   c_start: cover property (exec_start);
   c_drain: cover property ($fell(response_pending));
   c_long_abort: cover property ($fell(exec_abort) && rsa_keygen);
endmodule // cmd_fifo_monitor
bind cmd_fifo_handshake cmd_fifo_monitor #(.AW(AW), .ABORT_SHORT_CYC(ABORT_SHORT_CYC), .ABORT_LONG_CYC(ABORT_LONG_CYC))
   u_cmd_fifo_monitor (.clk(clk), .rst_b(rst_b), .fifo_wr_req(fifo_wr_req), .fifo_rd_req(fifo_rd_req),
   .execute_trigger_wr(execute_trigger_wr), .rsa_keygen(rsa_keygen), .bus_wait(bus_wait),
   .fifo_rd_valid(fifo_rd_valid), .prepare_command(prepare_command), .more_input_expected(more_input_expected),
   .response_pending(response_pending), .fifo_depth_count(fifo_depth_count), .exec_start(exec_start),
   .exec_abort(exec_abort));

// >>> dv/exec_engine_model.sv
// Behavioural execution engine facing the command FIFO block
`timescale 1ns/1ps
module exec_engine_model (
   // Bench controls
   input  wire       clk,
   input  wire       hold,
   input  wire       ack_en,
   input  wire [7:0] cmd_len,
   // Block side
   input  wire       exec_start,
   input  wire       exec_abort,
   input  wire       cmd_byte_valid,
   input  wire [7:0] cmd_byte,
   input  wire       rsp_ready,
   output reg        cmd_take,
   output reg        rsp_valid,
   output reg  [7:0] rsp_data,
   output reg        rsp_last,
   output reg        abort_ack,
   output reg  [7:0] got_sum
);
   integer i;
   // Clean state reported on abort; withheld to force the timeout path
   always @(posedge clk) abort_ack <= exec_abort & ack_en;
   // Drop the transfer in flight when the block aborts
   always @(posedge exec_abort) disable run;
   // Take the command bytes, then push a four-byte response
   initial begin
      rsp_data = 8'h00;
      got_sum = 8'h00;
      forever begin : run
         {cmd_take, rsp_valid, rsp_last} = 3'h0;
         @(negedge clk);
         if (exec_start === 1'b1) begin
            got_sum = 8'h00;
            for (i = 0; i < cmd_len; i = i + 1) begin
               cmd_take = 1'b1;
               @(negedge clk) cmd_take = 1'b0;
               got_sum = got_sum ^ (cmd_byte_valid ? cmd_byte : 8'h5a);
               @(negedge clk);
            end
            while (hold) @(negedge clk);
            for (i = 0; i < 4; i = i + 1) begin
               rsp_valid = 1'b1;
               rsp_data = 8'hc0 + i[7:0];
               rsp_last = (i == 3);
               #1;
               while (rsp_ready !== 1'b1) begin
                  @(negedge clk);
                  #1;
               end
               @(negedge clk);
            end
            rsp_data = ~rsp_data; // Stale data is not left on the lines
         end
      end
   end
endmodule // exec_engine_model

// >>> dv/cmd_fifo_handshake_tb.sv
// Self-checking bench for the command FIFO handshake block
`timescale 1ns/1ps
`include "cmd_fifo_defines.vh"
module cmd_fifo_handshake_tb;
   reg         clk, rst_b, fifo_wr_req, fifo_rd_req, hold, ack_en, rsa_keygen;
   reg  [7:0]  fifo_wr_data, cmd_len, exp_sum, q;
   reg  [4:0]  strobe;
   wire        bus_wait, fifo_rd_valid, prepare_command, more_input_expected, response_pending, rsp_last;
   wire        exec_start, exec_abort, abort_ack, cmd_take, cmd_byte_valid, rsp_valid, rsp_ready;
   wire [7:0]  fifo_rd_data, revision_id_register, cmd_byte, rsp_data, got_sum;
   wire [6:0]  fifo_depth_count;
   wire [31:0] device_vendor_ids;
   integer     miscompares = 0, comparisons = 0, n, i, k;
   // Block under test with short abort limits
   cmd_fifo_handshake #(.ABORT_SHORT_CYC(32'h14), .ABORT_LONG_CYC(32'h28)) u_cmd_fifo_handshake (
      .clk(clk), .rst_b(rst_b), .fifo_wr_req(fifo_wr_req), .fifo_wr_data(fifo_wr_data),
      .fifo_rd_req(fifo_rd_req), .bus_wait(bus_wait), .fifo_rd_valid(fifo_rd_valid), .fifo_rd_data(fifo_rd_data),
      .prepare_command_wr(strobe[0]), .execute_trigger_wr(strobe[1]), .locality_owned_wr(strobe[2]),
      .seize_ok(strobe[3]), .hash_start_done(strobe[4]), .prepare_command(prepare_command),
      .more_input_expected(more_input_expected), .response_pending(response_pending),
      .fifo_depth_count(fifo_depth_count), .device_vendor_ids(device_vendor_ids),
      .revision_id_register(revision_id_register), .exec_start(exec_start), .exec_abort(exec_abort),
      .abort_ack(abort_ack), .rsa_keygen(rsa_keygen), .cmd_take(cmd_take), .cmd_byte_valid(cmd_byte_valid),
      .cmd_byte(cmd_byte), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_last(rsp_last), .rsp_ready(rsp_ready));
   // Engine on the execution side
   exec_engine_model u_exec_engine_model (.clk(clk), .hold(hold), .ack_en(ack_en), .cmd_len(cmd_len),
      .exec_start(exec_start), .exec_abort(exec_abort), .cmd_byte_valid(cmd_byte_valid), .cmd_byte(cmd_byte),
      .rsp_ready(rsp_ready), .cmd_take(cmd_take), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
      .rsp_last(rsp_last), .abort_ack(abort_ack), .got_sum(got_sum));
   // 50 MHz clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task check(input [8*12-1:0] what, input [31:0] exp, input [31:0] got);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("[ERR] %0s expected %h seen %h", what, exp, got);
         end
      end
   endtask
   task summarize;
      begin
         $display("comparisons %0d miscompares %0d", comparisons, miscompares);
         if (miscompares == 0 && comparisons > 0) $display("Finished cleanly");
         else $display("Finished with errors");
         $finish;
      end
   endtask
   // One-cycle strobe: 0 prepare, 1 execute, 2 release, 3 takeover, 4 hash start
   task pulse(input integer s);
      begin
         @(negedge clk) strobe[s] = 1'b1;
         @(negedge clk) strobe[s] = 1'b0;
      end
   endtask
   // Data port access held until taken
   task access(input rd, input [7:0] b);
      begin
         @(negedge clk);
         {fifo_rd_req, fifo_wr_req, fifo_wr_data, n} = {rd, !rd, b, 32'h0};
         #1;
         while (bus_wait !== 1'b0 && n < 200) begin
            @(negedge clk);
            #1;
            n = n + 1;
         end
         if (n == 200) check("bus hold", 1, 0);
         if (n == 200) summarize;
         @(negedge clk);
         if (rd) check("rd valid", 1, fifo_rd_valid);
         q = fifo_rd_data;
         {fifo_rd_req, fifo_wr_req, fifo_wr_data} = {2'h0, ~b};
      end
   endtask
   // Bounded wait: 0 ready, 2 response readable, 3 abort over
   task wait_for(input integer s);
      begin
         n = 0;
         while (!(s == 0 ? prepare_command === 1'b1 && (|fifo_depth_count) === 1'b1 : s == 2 ?
               response_pending === 1'b1 && (|fifo_depth_count) === 1'b1 : exec_abort === 1'b0) && n < 300) begin
            @(negedge clk);
            n = n + 1;
         end
         if (n == 300) check("wait bound", 1, 0);
         if (n == 300) summarize;
      end
   endtask
   task send_cmd(input [7:0] len);
      begin
         cmd_len = len;
         pulse(0);
         wait_for(0);
         check("ready depth", 64, fifo_depth_count);
         exp_sum = 8'h00;
         for (i = 0; i < len; i = i + 1) begin
            q = (i == 5) ? len : (i > 1 && i < 5) ? 8'h00 : 8'h10 + i[7:0];
            exp_sum = exp_sum ^ q;
            access(1'b0, q);
            check("prepare", 0, prepare_command);
            check("expect", i != len - 1, more_input_expected);
            check("depth", i == len - 1 ? 0 : 63 - i, fifo_depth_count);
            if (i == 0) pulse(1);
            if (i == 0) check("early go", 0, exec_start);
         end
         access(1'b0, 8'hee);
         check("drop depth", 0, fifo_depth_count);
         pulse(1);
         check("go", 1, exec_start);
      end
   endtask
   task exchange;
      begin
         hold = 1'b0;
         send_cmd(8'h0a);
         wait_for(2);
         check("engine sum", exp_sum, got_sum);
         check("rsp depth", 4, fifo_depth_count);
         for (k = 0; k < 4; k = k + 1) begin
            access(1'b1, 8'h00);
            check("rsp byte", 8'hc0 + k, q);
            check("pending", k != 3, response_pending);
            check("rsp left", 3 - k, fifo_depth_count);
         end
         access(1'b1, 8'h00);
         check("empty read", 8'hff, q);
      end
   endtask
   // Reset, one exchange, four abort sources, then a clean exchange
   initial begin
      {rst_b, fifo_wr_req, fifo_rd_req, hold, ack_en, rsa_keygen} = 6'h0;
      {strobe, fifo_wr_data, cmd_len} = 21'h0;
      repeat (16) @(negedge clk);
      rst_b = 1'b1;
      @(negedge clk);
      check("reset flags", 0, {prepare_command, more_input_expected, response_pending, fifo_depth_count});
      check("ids", `DEV_VEN_ID_VAL, device_vendor_ids);
      check("rev id", `REV_ID_VAL, revision_id_register);
      pulse(1);
      check("idle go", 0, exec_start);
      exchange;
      for (k = 4; k < 8; k = k + 1) begin
         {hold, rsa_keygen, ack_en} = {1'b1, k[0], k < 6};
         send_cmd(8'h06);
         pulse(k == 4 ? 0 : k - 3);
         check("abort", 1, exec_abort);
         access(1'b1, 8'h00);
         check("stall read", 8'hff, q);
         wait_for(3);
         check("flushed", 0, {prepare_command, more_input_expected, response_pending, fifo_depth_count});
      end
      // Prepare during receive aborts back to idle
      pulse(0);
      wait_for(0);
      access(1'b0, 8'h10);
      pulse(0);
      check("recv abort", 0, {prepare_command, more_input_expected, response_pending, fifo_depth_count});
      exchange;
      summarize;
   end
endmodule // cmd_fifo_handshake_tb
